// ---- core/mul_div_unit_pkg.sv ----
package mul_div_unit_pkg;

  typedef enum logic [2:0] {
    mul_to_hilo_op = 3'h0,
    mul_accumulate_op = 3'h1,
    mul_subtract_op = 3'h2,
    mul_gpr_op = 3'h3,
    divide_op = 3'h4
  } mul_div_op_t;

  typedef enum logic [1:0] {
    div_idle = 2'b01,
    div_run = 2'b10
  } div_state_t;

  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned DWORD_W = 64;
  localparam int unsigned PROD_W = 50;
  localparam int unsigned BOOTH_DIGITS = 9;

  localparam int unsigned DIV_W8 = 8;
  localparam int unsigned DIV_W16 = 16;
  localparam int unsigned DIV_W24 = 24;

  localparam logic [5:0] ITERS_FULL = 6'h20;
  localparam logic [5:0] SKIP_W8 = 6'h17;
  localparam logic [5:0] SKIP_W16 = 6'h0f;
  localparam logic [5:0] SKIP_W24 = 6'h07;
  localparam logic [5:0] SKIP_W32 = 6'h00;

  localparam logic [5:0] REP_W8 = 6'h0b;
  localparam logic [5:0] REP_W16 = 6'h12;
  localparam logic [5:0] REP_W24 = 6'h19;
  localparam logic [5:0] REP_W32 = 6'h20;

  localparam logic [5:0] DIV_CNT_LAST = 6'h01;
  localparam logic [5:0] DIV_CNT_STALL = 6'h02;
  localparam logic [5:0] DIV_CNT_RST = 6'h00;

  localparam logic [31:0] RESULT_RST = 32'h0;

endpackage

// ---- core/booth_mul_32x16.sv ----
`timescale 1ns/1ns
module booth_mul_32x16
(
  input logic signed [mul_div_unit_pkg::WORD_W:0] a_i,
  input logic signed [mul_div_unit_pkg::HALF_W:0] b_i,
  output logic signed [mul_div_unit_pkg::PROD_W-1:0] prod_o
);
  import mul_div_unit_pkg::*;

  logic [HALF_W+2:0] bp;
  logic signed [PROD_W-1:0] ae;
  logic signed [PROD_W-1:0] pp;
  logic signed [PROD_W-1:0] acc;

  // radix-4 booth recoding: nine digits cover the 17-bit signed multiplier
  always_comb
  begin
    bp = {b_i[HALF_W], b_i, 1'b0};
    ae = PROD_W'(a_i);
    acc = '0;
    pp = '0;
    for (int i = 0; i < BOOTH_DIGITS; i++)
    begin
      case (bp[2*i +: 3])
        3'b001, 3'b010: pp = ae;
        3'b011: pp = ae <<< 1;
        3'b100: pp = -(ae <<< 1);
        3'b101, 3'b110: pp = -ae;
        default: pp = '0;
      endcase
      acc = acc + (pp <<< (2 * i));
    end
    prod_o = acc;
  end

endmodule

// ---- core/mul_div_unit.sv ----
`timescale 1ns/1ns
// How it works
// - 32x16 booth array; pass count comes only from the second operand width
// - narrow second operand takes one pass, full width takes two
// - narrow multiplies accepted every cycle, wide ones every other cycle
// - wide multiply raises stall for one cycle so the next waits
// - operand width is detected internally, no size input exists
// - multiply and divide pipelines advance on their own, never held by issue stalls
// - unit holds high/low result registers, divide machine, muxing and control
// - divider resolves one quotient bit per clock once its leading pad cycles have passed
// - dividend sign extension skips 23, 15 or 7 iterations
// - any issue during an active divide is stalled until the divide's final iteration cycle
// - result-register multiplies: latency/repeat 1/1 narrow, 2/2 wide
// - general-register multiply: latency/repeat 2/1 narrow, 3/2 wide
// - divides take 12/11, 19/18, 26/25, 33/32 cycles by dividend width
module mul_div_unit
(
  input logic mclk_i,
  input logic srst_i,
  input logic issue_valid_i,
  input mul_div_unit_pkg::mul_div_op_t issue_op_i,
  input logic issue_signed_i,
  input logic [mul_div_unit_pkg::WORD_W-1:0] first_operand_i,
  input logic [mul_div_unit_pkg::WORD_W-1:0] second_operand_i,
  output logic stall_o,
  output logic busy_o,
  output logic [mul_div_unit_pkg::WORD_W-1:0] result_high_reg_o,
  output logic [mul_div_unit_pkg::WORD_W-1:0] result_low_reg_o,
  output logic [mul_div_unit_pkg::WORD_W-1:0] gpr_result_o,
  output logic gpr_valid_o
);
  import mul_div_unit_pkg::*;

  function automatic logic fits_in(input logic [WORD_W-1:0] v, input logic sgn,
                                   input int unsigned w);
    logic [WORD_W-1:0] hi_mask;
    hi_mask = sgn ? ('1 << (w - 1)) : ('1 << w);
    return ((v & hi_mask) == '0) || (sgn && ((v & hi_mask) == hi_mask));
  endfunction

  logic stall_q, stall_d, busy_q, busy_d;
  logic [WORD_W-1:0] high_q, high_d, low_q, low_d;
  logic [WORD_W-1:0] gpr_stage_q, gpr_stage_d, gpr_q, gpr_d;
  logic gpr_stage_valid_q, gpr_stage_valid_d, gpr_valid_q, gpr_valid_d;

  logic mp_valid_q, mp_valid_d, mp_wide_q, mp_wide_d, mp_second_q, mp_second_d;
  logic mp_sign_q, mp_sign_d;
  mul_div_op_t mp_op_q, mp_op_d;
  logic signed [WORD_W:0] mp_a_q, mp_a_d;
  logic [WORD_W-1:0] mp_b_q, mp_b_d;
  logic [DWORD_W-1:0] mp_partial_q, mp_partial_d;
  logic [HALF_W:0] mp_b_sel;
  logic signed [PROD_W-1:0] prod;
  logic [DWORD_W-1:0] prod_ext, mul_full, acc_base, hilo_new;
  logic mul_final;

  div_state_t div_state_q, div_state_d;
  logic [5:0] div_cnt_q, div_cnt_d, div_iters_q, div_iters_d;
  logic [WORD_W-1:0] div_dq_q, div_dq_d, div_rem_q, div_rem_d, div_dvs_q, div_dvs_d;
  logic div_negq_q, div_negq_d, div_negr_q, div_negr_d;
  logic fix_valid_q, fix_valid_d, fix_negq_q, fix_negq_d, fix_negr_q, fix_negr_d;
  logic [WORD_W-1:0] fix_quo_q, fix_quo_d, fix_rem_q, fix_rem_d, quo_fix, rem_fix;
  logic [WORD_W:0] div_sh;
  logic [WORD_W+1:0] div_diff;
  logic div_ge, div_step, div_last;
  logic [WORD_W-1:0] abs_a, abs_b;
  logic [5:0] skip, rep;

  logic issue_take, mul_take, div_take, narrow_b, div_w8, div_w16, div_w24;

  // refused issues are simply not taken; the pipeline must hold them
  assign issue_take = issue_valid_i && !stall_q;
  assign mul_take = issue_take && (issue_op_i != divide_op);
  assign div_take = issue_take && (issue_op_i == divide_op);
  // width from the second operand value alone, no size hint from outside
  assign narrow_b = fits_in(second_operand_i, issue_signed_i, HALF_W);
  assign div_w8 = fits_in(first_operand_i, issue_signed_i, DIV_W8);
  assign div_w16 = fits_in(first_operand_i, issue_signed_i, DIV_W16);
  assign div_w24 = fits_in(first_operand_i, issue_signed_i, DIV_W24);

  booth_mul_32x16 u_array
  (
    .a_i(mp_a_q),
    .b_i(mp_b_sel),
    .prod_o(prod)
  );

  // multiply pipeline: never held by issue stalls, pass two always follows pass one
  always_comb
  begin
    mp_b_sel = mp_second_q ? {mp_sign_q & mp_b_q[WORD_W-1], mp_b_q[WORD_W-1:HALF_W]}
                           : {mp_sign_q & !mp_wide_q & mp_b_q[HALF_W-1], mp_b_q[HALF_W-1:0]};
    prod_ext = {{(DWORD_W-PROD_W){prod[PROD_W-1]}}, prod};
    mul_full = mp_second_q ? mp_partial_q + (prod_ext << HALF_W) : prod_ext;
    mul_final = mp_valid_q && (!mp_wide_q || mp_second_q);
    mp_op_d = mp_op_q;
    mp_a_d = mp_a_q;
    mp_b_d = mp_b_q;
    mp_sign_d = mp_sign_q;
    mp_wide_d = mp_wide_q;
    mp_partial_d = prod_ext;
    mp_second_d = mp_valid_q && mp_wide_q && !mp_second_q;
    mp_valid_d = mp_valid_q && mp_wide_q && !mp_second_q;
    if (mul_take)
    begin
      mp_valid_d = 1'b1;
      mp_second_d = 1'b0;
      mp_op_d = issue_op_i;
      mp_sign_d = issue_signed_i;
      mp_a_d = {issue_signed_i & first_operand_i[WORD_W-1], first_operand_i};
      mp_b_d = second_operand_i;
      mp_wide_d = !narrow_b;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      mp_valid_q <= 1'b0;
      mp_second_q <= 1'b0;
      mp_wide_q <= 1'b0;
      mp_sign_q <= 1'b0;
      mp_op_q <= mul_to_hilo_op;
      mp_a_q <= '0;
      mp_b_q <= '0;
      mp_partial_q <= '0;
    end
    else
    begin
      mp_valid_q <= mp_valid_d;
      mp_second_q <= mp_second_d;
      mp_wide_q <= mp_wide_d;
      mp_sign_q <= mp_sign_d;
      mp_op_q <= mp_op_d;
      mp_a_q <= mp_a_d;
      mp_b_q <= mp_b_d;
      mp_partial_q <= mp_partial_d;
    end
  end

  // divider: leading cycles only pad to the fixed repeat count, then one bit per cycle
  always_comb
  begin
    abs_a = (issue_signed_i && first_operand_i[WORD_W-1]) ? -first_operand_i : first_operand_i;
    abs_b = (issue_signed_i && second_operand_i[WORD_W-1]) ? -second_operand_i
                                                          : second_operand_i;
    if (div_w8)
    begin
      skip = SKIP_W8;
      rep = REP_W8;
    end
    else if (div_w16)
    begin
      skip = SKIP_W16;
      rep = REP_W16;
    end
    else if (div_w24)
    begin
      skip = SKIP_W24;
      rep = REP_W24;
    end
    else
    begin
      skip = SKIP_W32;
      rep = REP_W32;
    end
    div_sh = {div_rem_q, div_dq_q[WORD_W-1]};
    div_diff = {1'b0, div_sh} - {2'b00, div_dvs_q};
    div_ge = !div_diff[WORD_W+1];
    div_step = (div_state_q == div_run) && (div_cnt_q <= div_iters_q);
    div_last = (div_state_q == div_run) && (div_cnt_q == DIV_CNT_LAST);
    div_state_d = div_state_q;
    div_cnt_d = div_cnt_q;
    div_iters_d = div_iters_q;
    div_dq_d = div_dq_q;
    div_rem_d = div_rem_q;
    div_dvs_d = div_dvs_q;
    div_negq_d = div_negq_q;
    div_negr_d = div_negr_q;
    if (div_state_q == div_run)
      div_cnt_d = div_cnt_q - DIV_CNT_LAST;
    if (div_step)
    begin
      div_rem_d = div_ge ? div_diff[WORD_W-1:0] : div_sh[WORD_W-1:0];
      div_dq_d = {div_dq_q[WORD_W-2:0], div_ge};
    end
    fix_valid_d = div_last;
    fix_quo_d = div_last ? div_dq_d : fix_quo_q;
    fix_rem_d = div_last ? div_rem_d : fix_rem_q;
    fix_negq_d = div_last ? div_negq_q : fix_negq_q;
    fix_negr_d = div_last ? div_negr_q : fix_negr_q;
    if (div_last)
      div_state_d = div_idle;
    if (div_take)
    begin
      div_state_d = div_run;
      div_cnt_d = rep;
      div_iters_d = ITERS_FULL - skip;
      div_dq_d = abs_a << skip;
      div_rem_d = '0;
      div_dvs_d = abs_b;
      div_negq_d = issue_signed_i && (first_operand_i[WORD_W-1] ^ second_operand_i[WORD_W-1]);
      div_negr_d = issue_signed_i && first_operand_i[WORD_W-1];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      div_state_q <= div_idle;
      div_cnt_q <= DIV_CNT_RST;
      div_iters_q <= DIV_CNT_RST;
      div_dq_q <= '0;
      div_rem_q <= '0;
      div_dvs_q <= '0;
      div_negq_q <= 1'b0;
      div_negr_q <= 1'b0;
      fix_valid_q <= 1'b0;
      fix_quo_q <= '0;
      fix_rem_q <= '0;
      fix_negq_q <= 1'b0;
      fix_negr_q <= 1'b0;
    end
    else
    begin
      div_state_q <= div_state_d;
      div_cnt_q <= div_cnt_d;
      div_iters_q <= div_iters_d;
      div_dq_q <= div_dq_d;
      div_rem_q <= div_rem_d;
      div_dvs_q <= div_dvs_d;
      div_negq_q <= div_negq_d;
      div_negr_q <= div_negr_d;
      fix_valid_q <= fix_valid_d;
      fix_quo_q <= fix_quo_d;
      fix_rem_q <= fix_rem_d;
      fix_negq_q <= fix_negq_d;
      fix_negr_q <= fix_negr_d;
    end
  end

  // results; a divide finishing under a multiply is forwarded as the accumulate base
  always_comb
  begin
    quo_fix = fix_negq_q ? -fix_quo_q : fix_quo_q;
    rem_fix = fix_negr_q ? -fix_rem_q : fix_rem_q;
    acc_base = fix_valid_q ? {rem_fix, quo_fix} : {high_q, low_q};
    case (mp_op_q)
      mul_accumulate_op: hilo_new = acc_base + mul_full;
      mul_subtract_op: hilo_new = acc_base - mul_full;
      default: hilo_new = mul_full;
    endcase
    high_d = high_q;
    low_d = low_q;
    if (mul_final && (mp_op_q != mul_gpr_op))
      {high_d, low_d} = hilo_new;
    else if (fix_valid_q)
      {high_d, low_d} = {rem_fix, quo_fix};
    gpr_stage_valid_d = mul_final && (mp_op_q == mul_gpr_op);
    gpr_stage_d = gpr_stage_valid_d ? mul_full[WORD_W-1:0] : gpr_stage_q;
    // extra stage gives the general-register multiply its longer latency
    gpr_valid_d = gpr_stage_valid_q;
    gpr_d = gpr_stage_valid_q ? gpr_stage_q : gpr_q;
    stall_d = (mul_take && !narrow_b)
              || ((div_state_d == div_run) && (div_cnt_d >= DIV_CNT_STALL));
    busy_d = mp_valid_d || (div_state_d == div_run) || fix_valid_d;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      high_q <= RESULT_RST;
      low_q <= RESULT_RST;
      gpr_stage_q <= RESULT_RST;
      gpr_q <= RESULT_RST;
      gpr_stage_valid_q <= 1'b0;
      gpr_valid_q <= 1'b0;
      stall_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      high_q <= high_d;
      low_q <= low_d;
      gpr_stage_q <= gpr_stage_d;
      gpr_q <= gpr_d;
      gpr_stage_valid_q <= gpr_stage_valid_d;
      gpr_valid_q <= gpr_valid_d;
      stall_q <= stall_d;
      busy_q <= busy_d;
    end
  end

  assign stall_o = stall_q;
  assign busy_o = busy_q;
  assign result_high_reg_o = high_q;
  assign result_low_reg_o = low_q;
  assign gpr_result_o = gpr_q;
  assign gpr_valid_o = gpr_valid_q;

  logic [DWORD_W-1:0] chk_prod;
  assign chk_prod = DWORD_W'(first_operand_i) * DWORD_W'(second_operand_i);

  sequence s_two_pass;
    !mul_final ##1 mul_final;
  endsequence

  sequence s_one_cycle_stall;
    stall_o ##1 !stall_o;
  endsequence

  property p_narrow_one_pass;
    @(posedge mclk_i) disable iff (srst_i)
    mul_take && narrow_b |=> mul_final;
  endproperty
  a_narrow_one_pass: assert property (p_narrow_one_pass)
    else $error("narrow multiply did not finish in one pass");

  property p_wide_two_pass;
    @(posedge mclk_i) disable iff (srst_i)
    mul_take && !narrow_b |=> s_two_pass;
  endproperty
  a_wide_two_pass: assert property (p_wide_two_pass)
    else $error("wide multiply did not take two passes");

  property p_narrow_rate;
    @(posedge mclk_i) disable iff (srst_i)
    mul_take && narrow_b && (div_state_q == div_idle) |=> !stall_o;
  endproperty
  a_narrow_rate: assert property (p_narrow_rate)
    else $error("narrow multiply blocked the next issue");

  property p_wide_stall;
    @(posedge mclk_i) disable iff (srst_i)
    mul_take && !narrow_b && (div_state_q == div_idle) |=> s_one_cycle_stall;
  endproperty
  a_wide_stall: assert property (p_wide_stall)
    else $error("wide multiply stall not exactly one cycle");

  property p_hilo_narrow;
    @(posedge mclk_i) disable iff (srst_i)
    mul_take && narrow_b && !issue_signed_i && (issue_op_i == mul_to_hilo_op)
      |-> ##2 ({result_high_reg_o, result_low_reg_o} == $past(chk_prod, 2));
  endproperty
  a_hilo_narrow: assert property (p_hilo_narrow)
    else $error("narrow multiply result late or wrong");

  property p_hilo_wide;
    @(posedge mclk_i) disable iff (srst_i)
    mul_take && !narrow_b && !issue_signed_i && (issue_op_i == mul_to_hilo_op)
      |-> ##3 ({result_high_reg_o, result_low_reg_o} == $past(chk_prod, 3));
  endproperty
  a_hilo_wide: assert property (p_hilo_wide)
    else $error("wide multiply result late or wrong");

  // width is judged at issue; later operand lines belong to other requests
  property p_gpr_latency;
    @(posedge mclk_i) disable iff (srst_i)
    mul_take && (issue_op_i == mul_gpr_op) && narrow_b
      |-> ##3 gpr_valid_o && (gpr_result_o == $past(chk_prod[WORD_W-1:0], 3));
  endproperty
  a_gpr_latency: assert property (p_gpr_latency)
    else $error("general-register multiply latency wrong");

  property p_gpr_latency_wide;
    @(posedge mclk_i) disable iff (srst_i)
    mul_take && (issue_op_i == mul_gpr_op) && !narrow_b
      |-> ##4 gpr_valid_o && (gpr_result_o == $past(chk_prod[WORD_W-1:0], 4));
  endproperty
  a_gpr_latency_wide: assert property (p_gpr_latency_wide)
    else $error("wide general-register multiply latency wrong");

  property p_div_one_bit;
    @(posedge mclk_i) disable iff (srst_i)
    (div_state_q == div_run) && (div_cnt_q > DIV_CNT_LAST)
      |=> div_cnt_q == $past(div_cnt_q) - DIV_CNT_LAST;
  endproperty
  a_div_one_bit: assert property (p_div_one_bit)
    else $error("divider count did not step by one");

  property p_div_skip8;
    @(posedge mclk_i) disable iff (srst_i)
    div_take && div_w8 |=> div_iters_q == 6'h09;
  endproperty
  a_div_skip8: assert property (p_div_skip8)
    else $error("narrow dividend did not skip iterations");

  property p_div_stall;
    @(posedge mclk_i) disable iff (srst_i)
    div_take && !div_w24 |=> stall_o[*8];
  endproperty
  a_div_stall: assert property (p_div_stall)
    else $error("issue not stalled during divide");

  property p_div_latency;
    @(posedge mclk_i) disable iff (srst_i)
    div_take && div_w8 |-> ##10 stall_o ##1 !stall_o && !fix_valid_q ##1 fix_valid_q;
  endproperty
  a_div_latency: assert property (p_div_latency)
    else $error("short divide timing wrong");

  property p_div_latency32;
    @(posedge mclk_i) disable iff (srst_i)
    div_take && !div_w24 |-> ##31 stall_o ##1 !stall_o && !fix_valid_q ##1 fix_valid_q;
  endproperty
  a_div_latency32: assert property (p_div_latency32)
    else $error("full divide timing wrong");

  property p_div_result;
    @(posedge mclk_i) disable iff (srst_i)
    fix_valid_q && !mul_final |=> (result_low_reg_o == $past(quo_fix))
      && (result_high_reg_o == $past(rem_fix));
  endproperty
  a_div_result: assert property (p_div_result)
    else $error("divide result not placed in result registers");

endmodule

// ---- tb/issue_pipe_model.sv ----
`timescale 1ns/1ns
module issue_pipe_model
(
  input logic mclk_i,
  input logic stall_i,
  output logic issue_valid_o,
  output mul_div_unit_pkg::mul_div_op_t issue_op_o,
  output logic issue_signed_o,
  output logic [mul_div_unit_pkg::WORD_W-1:0] first_operand_o,
  output logic [mul_div_unit_pkg::WORD_W-1:0] second_operand_o
);
  import mul_div_unit_pkg::*;

  initial
  begin
    issue_valid_o = 1'b0;
    issue_op_o = mul_to_hilo_op;
    issue_signed_o = 1'b0;
    first_operand_o = 32'h0;
    second_operand_o = 32'h0;
  end

  // call just after a rising edge; returns at the edge that takes the request
  task automatic issue(input mul_div_op_t op, input logic sgn, input logic [31:0] a,
                       input logic [31:0] b, output int waits);
    logic s;
    waits = 0;
    issue_valid_o <= 1'b1;
    issue_op_o <= op;
    issue_signed_o <= sgn;
    first_operand_o <= a;
    second_operand_o <= b;
    // stall is sampled mid-cycle so it matches what the unit sees at the edge
    do
    begin
      @(negedge mclk_i);
      s = stall_i;
      @(posedge mclk_i);
      if (s !== 1'b0)
        waits++;
    end
    while (s !== 1'b0 && waits < 40);
    if (s !== 1'b0)
      waits = -1;
  endtask

  // released operand lines toggle so stale values are never mistaken for live ones
  task automatic idle();
    issue_valid_o <= 1'b0;
    first_operand_o <= ~first_operand_o;
    second_operand_o <= ~second_operand_o;
  endtask
endmodule

// ---- tb/mul_div_unit_tb.sv ----
`timescale 1ns/1ns
module mul_div_unit_tb;
  import mul_div_unit_pkg::*;

  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic issue_valid;
  mul_div_op_t issue_op;
  logic issue_signed;
  logic [31:0] first_operand;
  logic [31:0] second_operand;
  logic stall;
  logic busy;
  logic [31:0] high_reg;
  logic [31:0] low_reg;
  logic [31:0] gpr_result;
  logic gpr_valid;
  logic [63:0] hilo;
  logic [63:0] exp_hilo = 64'h0;
  int err_total = 0;
  int compares = 0;

  assign hilo = {high_reg, low_reg};

  always #50 mclk_i = ~mclk_i;

  mul_div_unit mul_div_unit_i (.mclk_i(mclk_i), .srst_i(srst_i), .issue_valid_i(issue_valid),
    .issue_op_i(issue_op), .issue_signed_i(issue_signed), .first_operand_i(first_operand),
    .second_operand_i(second_operand), .stall_o(stall), .busy_o(busy),
    .result_high_reg_o(high_reg), .result_low_reg_o(low_reg), .gpr_result_o(gpr_result),
    .gpr_valid_o(gpr_valid));

  issue_pipe_model issue_pipe_model_i (.mclk_i(mclk_i), .stall_i(stall),
    .issue_valid_o(issue_valid), .issue_op_o(issue_op), .issue_signed_o(issue_signed),
    .first_operand_o(first_operand), .second_operand_o(second_operand));

  function automatic logic [63:0] prod(logic [31:0] a, logic [31:0] b, logic sgn);
    if (sgn)
      return longint'($signed(a)) * longint'($signed(b));
    return {32'h0, a} * {32'h0, b};
  endfunction

  task automatic chk_val(string name, logic [63:0] exp, logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic chk_cnt(string name, int exp, int got);
    compares++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
      err_total++;
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // present one request and compare how many edges refused it
  task automatic take(mul_div_op_t op, logic sgn, logic [31:0] a, logic [31:0] b, int exp_wait);
    int w;
    issue_pipe_model_i.issue(op, sgn, a, b, w);
    if (w < 0)
    begin
      err_total++;
      results();
    end
    else
      chk_cnt("refused edges", exp_wait, w);
  endtask

  task automatic next_cycle();
    @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  task automatic t_reset();
    chk_val("stall busy gpr_valid", 64'h0, {61'h0, stall, busy, gpr_valid});
    chk_val("high low", 64'h0, hilo);
    chk_val("gpr result", 64'h0, {32'h0, gpr_result});
  endtask

  // narrow operands back to back, unsigned then signed
  task automatic t_narrow();
    @(posedge mclk_i);
    take(mul_to_hilo_op, 1'b0, 32'h89abcdef, 32'h0000ffff, 0);
    take(mul_to_hilo_op, 1'b1, 32'h80000000, 32'hffff8000, 0);
    issue_pipe_model_i.idle();
    @(negedge mclk_i);
    chk_val("high low narrow u", prod(32'h89abcdef, 32'h0000ffff, 1'b0), hilo);
    next_cycle();
    exp_hilo = prod(32'h80000000, 32'hffff8000, 1'b1);
    chk_val("high low narrow s", exp_hilo, hilo);
  endtask

  // back-to-back full-width multiplies: the second is held one edge
  task automatic t_wide();
    @(posedge mclk_i);
    take(mul_to_hilo_op, 1'b0, 32'hdeadbeef, 32'h00010000, 0);
    take(mul_to_hilo_op, 1'b1, 32'h7fffffff, 32'h80000001, 1);
    issue_pipe_model_i.idle();
    @(negedge mclk_i);
    exp_hilo = prod(32'hdeadbeef, 32'h00010000, 1'b0);
    chk_val("high low wide 1", exp_hilo, hilo);
    next_cycle();
    chk_val("busy mid pass", 64'h1, {63'h0, busy});
    chk_val("high low wide early", exp_hilo, hilo);
    next_cycle();
    exp_hilo = prod(32'h7fffffff, 32'h80000001, 1'b1);
    chk_val("high low wide 2", exp_hilo, hilo);
  endtask

  // load, accumulate, then a wide subtract straight after a narrow op
  task automatic t_acc();
    @(posedge mclk_i);
    take(mul_to_hilo_op, 1'b0, 32'h00001234, 32'h00005678, 0);
    take(mul_accumulate_op, 1'b1, 32'hfffffff0, 32'h00007000, 0);
    take(mul_subtract_op, 1'b0, 32'h00000003, 32'h40000000, 0);
    issue_pipe_model_i.idle();
    @(negedge mclk_i);
    exp_hilo = prod(32'h00001234, 32'h00005678, 1'b0) + prod(32'hfffffff0, 32'h00007000, 1'b1);
    chk_val("high low accumulate", exp_hilo, hilo);
    next_cycle();
    next_cycle();
    exp_hilo = exp_hilo - prod(32'h00000003, 32'h40000000, 1'b0);
    chk_val("high low subtract", exp_hilo, hilo);
  endtask

  // general-register multiply; issue drops at once, the unit carries on alone
  task automatic t_gpr(logic [31:0] a, logic [31:0] b, logic sgn, int lat);
    logic [63:0] p;
    p = prod(a, b, sgn);
    @(posedge mclk_i);
    take(mul_gpr_op, sgn, a, b, 0);
    issue_pipe_model_i.idle();
    for (int i = 1; i <= 4; i++)
    begin
      next_cycle();
      chk_val("gpr valid", {63'h0, i == lat}, {63'h0, gpr_valid});
    end
    chk_val("gpr result", {32'h0, p[31:0]}, {32'h0, gpr_result});
    chk_val("high low kept", exp_hilo, hilo);
  endtask

  // divide, with a follow-on request held until the repeat time runs out
  task automatic t_div(logic [31:0] a, logic [31:0] b, logic sgn, int rep);
    logic [31:0] q;
    logic [31:0] r;
    if (sgn)
    begin
      q = $signed(a) / $signed(b);
      r = $signed(a) % $signed(b);
    end
    else
    begin
      q = a / b;
      r = a % b;
    end
    @(posedge mclk_i);
    take(divide_op, sgn, a, b, 0);
    take(mul_gpr_op, 1'b0, 32'h00000003, 32'h00000005, rep - 1);
    issue_pipe_model_i.idle();
    @(negedge mclk_i);
    chk_val("high low before divide end", exp_hilo, hilo);
    next_cycle();
    exp_hilo = {r, q};
    chk_val("remainder quotient", exp_hilo, hilo);
  endtask

  initial
  begin
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(negedge mclk_i);
    t_reset();
    t_narrow();
    t_wide();
    t_acc();
    t_gpr(32'h12345678, 32'hffff9abc, 1'b1, 2);
    t_gpr(32'h12345678, 32'h9abcdef0, 1'b0, 3);
    t_div(32'h000000c8, 32'h00000007, 1'b0, 11);
    t_div(32'hfffffc18, 32'h00000007, 1'b1, 18);
    t_div(32'h00abcdef, 32'h00000100, 1'b0, 25);
    t_div(32'hfedcba98, 32'h00000003, 1'b0, 32);
    t_div(32'h80000001, 32'hfffffffd, 1'b1, 32);
    results();
  end
endmodule
